// [common/sdram_pkg.sv]
// Shared constants, pin bundle and enumerations of the SDRAM device core.
// Assumes one 100 MHz clock and a classic Wishbone register port.
package sdram_pkg;

  // ==========================================================================
  // Geometry
  localparam int BANKS     = 4;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 8;
  localparam int DQ_W      = 16;
  localparam int AP_BIT    = 10;    // Auto precharge bit position in address
  localparam int REF_CNT_W = 12;    // Internal refresh row counter width

  // ==========================================================================
  // Pin bundle seen from the controller
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [1:0]        ba;        // bank_select_high, bank_select_low
    logic [ROW_W-1:0]  addr;
    logic [1:0]        dqm;       // Byte mask, bit 1 upper byte
  } sdram_pins_t;

  typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE,
                CMD_REF, CMD_LMR} cmd_t;

  typedef enum {MODE_RUN, MODE_SELF, MODE_DEEP} mode_t;

  // ==========================================================================
  // Register map (byte offsets) and fields
  localparam logic [7:0] CFG_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] REFCNT_OFS  = 8'h08;
  localparam int         CFG_CL_POS  = 0;   // Two bits of CAS latency
  localparam int         CFG_BL_POS  = 2;   // Two bits, burst = 1 << code
  localparam logic [1:0] CL_RST      = 2'h3;
  localparam logic [1:0] BL_RST      = 2'h2;
  localparam int         ST_OPEN_POS = 0;   // Four bank-open bits
  localparam int         ST_SELF_POS = 4;
  localparam int         ST_DEEP_POS = 5;
  localparam int         ST_LOST_POS = 6;   // Write one to clear
  localparam int         ST_BUSY_POS = 7;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS        = 10;
  localparam int REFRESH_INTERVAL_NS  = 15625;
  localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;

endpackage : sdram_pkg

// [logic/sdram_device.sv]
// Command-level SDRAM device core: banks, bursts, refresh and power modes.
// Assumes pins are synchronous to mclk and a classic Wishbone master.
// What this block does
// - Auto precharge closes the addressed bank when that one burst completes.
// - Auto refresh uses internal row counter, one refresh per command.
// - Refresh encoding with clock gate low enters self refresh.
// - Self refresh runs internal timing and refreshes by itself.
// - Deep power-down entry with banks idle; clock gate high exits.
// - Read data after CAS latency 2 or 3 (lower codes act as 2), one per edge, then float.
// - A new read truncates the previous one on any clock.
// - A registered write floats the data pins at once.
// - Auto precharge bit high enables, low disables, per access.
// - Refresh encoding is auto refresh with gate high, self refresh low.
module sdram_device #(
  parameter int ROW_W = sdram_pkg::ROW_W,
  parameter int COL_W = sdram_pkg::COL_W
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output      logic                      wb_ack_o,
  output      logic [31:0]               wb_dat_o,
  // SDRAM pins
  input  wire sdram_pkg::sdram_pins_t    pins,
  input  wire logic [sdram_pkg::DQ_W-1:0] dq_in,
  output      logic [sdram_pkg::DQ_W-1:0] dq_out,
  output      logic [1:0]                dq_oe_n
);

  localparam int DW = sdram_pkg::DQ_W;
  localparam int AW = 2 + ROW_W + COL_W;

  // ==========================================================================
  // Command decode
  function automatic sdram_pkg::cmd_t decode(input sdram_pkg::sdram_pins_t p);
    if (p.cs_n) return sdram_pkg::CMD_NOP;
    case ({p.ras_n, p.cas_n, p.we_n})
      3'h3:    return sdram_pkg::CMD_ACT;
      3'h5:    return sdram_pkg::CMD_RD;
      3'h4:    return sdram_pkg::CMD_WR;
      3'h6:    return sdram_pkg::CMD_BST;
      3'h2:    return sdram_pkg::CMD_PRE;
      3'h1:    return sdram_pkg::CMD_REF;
      3'h0:    return sdram_pkg::CMD_LMR;
      default: return sdram_pkg::CMD_NOP;
    endcase
  endfunction : decode

  sdram_pkg::cmd_t  cmd;
  sdram_pkg::mode_t mode_r;
  logic [1:0]       cl_r, bl_code_r;
  logic [3:0]       bl;
  logic             run, is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_col;
  logic             stop_burst;

  assign cmd    = decode(pins);
  // Outside run mode every pin but the clock gate is ignored
  assign run    = (mode_r == sdram_pkg::MODE_RUN) && pins.cke;
  assign is_act = run && cmd == sdram_pkg::CMD_ACT;
  assign is_rd  = run && cmd == sdram_pkg::CMD_RD;
  assign is_wr  = run && cmd == sdram_pkg::CMD_WR;
  assign is_bst = run && cmd == sdram_pkg::CMD_BST;
  assign is_pre = run && cmd == sdram_pkg::CMD_PRE;
  assign is_ref = run && cmd == sdram_pkg::CMD_REF;
  assign is_col = is_rd || is_wr;
  assign bl     = 4'h1 << bl_code_r;

  // ==========================================================================
  // Burst engine: one column element addressed per clock
  logic [3:0]       left_r;
  logic [1:0]       bbank_r;
  logic [COL_W-1:0] bcol_r;
  logic             bwr_r, bap_r;
  logic             cur_v, cur_wr, cur_last_ap;
  logic [1:0]       cur_bank;
  logic [COL_W-1:0] cur_col;

  assign stop_burst = is_bst ||
                      (is_pre && (pins.addr[sdram_pkg::AP_BIT] ||
                                  pins.ba == bbank_r));
  always_comb begin
    cur_v       = is_col || (left_r != 4'h0 && !stop_burst);
    cur_wr      = is_col ? is_wr : bwr_r;
    cur_bank    = is_col ? pins.ba : bbank_r;
    cur_col     = is_col ? pins.addr[COL_W-1:0] : bcol_r;
    // Last element of an auto-precharge burst is being addressed
    cur_last_ap = is_col ? (pins.addr[sdram_pkg::AP_BIT] && bl == 4'h1)
                         : (left_r == 4'h1 && bap_r && !stop_burst);
  end

  // New column command restarts the engine, truncating the old burst
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left_r  <= 4'h0;
      bbank_r <= 2'h0;
      bcol_r  <= '0;
      bwr_r   <= 1'b0;
      bap_r   <= 1'b0;
    end else if (is_col) begin
      left_r  <= bl - 4'h1;
      bbank_r <= pins.ba;
      bcol_r  <= pins.addr[COL_W-1:0] + 1'b1;
      bwr_r   <= is_wr;
      bap_r   <= pins.addr[sdram_pkg::AP_BIT];
    end else if (stop_burst) begin
      left_r  <= 4'h0;
      bap_r   <= 1'b0;
    end else if (left_r != 4'h0) begin
      left_r  <= left_r - 4'h1;
      bcol_r  <= bcol_r + 1'b1;                 // Wraps inside the page
    end
  end

  // ==========================================================================
  // Bank state
  localparam int BANKS_C = sdram_pkg::BANKS;
  logic [BANKS_C-1:0] open_r;
  logic [ROW_W-1:0]   row_r [BANKS_C];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      open_r <= '0;
      for (int b = 0; b < BANKS_C; b++) row_r[b] <= '0;
    end else begin
      if (cur_v && cur_last_ap) open_r[cur_bank] <= 1'b0;
      if (is_pre && pins.addr[sdram_pkg::AP_BIT]) open_r <= '0;
      else if (is_pre) open_r[pins.ba] <= 1'b0;
      if (is_act) begin
        open_r[pins.ba] <= 1'b1;
        row_r[pins.ba]  <= pins.addr;
      end
    end
  end

  // ==========================================================================
  // Array and read pipeline
  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] idx;
  logic [1:0]    pv_r;
  logic [DW-1:0] pd_r [2];
  logic [1:0]    dqm_d1_r;
  logic          sel_v;
  logic [DW-1:0] sel_d;

  assign idx   = {cur_bank, row_r[cur_bank], cur_col};
  // Stage picked so data is valid 3 edges after the command at latency 3, 2 edges at any other latency
  assign sel_v = (cl_r == 2'h3) ? pv_r[1] : pv_r[0];
  assign sel_d = (cl_r == 2'h3) ? pd_r[1] : pd_r[0];

  // Write data and mask taken with no latency
  always_ff @(posedge mclk) begin
    if (cur_v && cur_wr)
      for (int b = 0; b < 2; b++)
        if (!pins.dqm[b]) mem[idx][b*8 +: 8] <= dq_in[b*8 +: 8];
  end

  always_ff @(posedge mclk) begin
    pd_r[0] <= mem[idx];
    pd_r[1] <= pd_r[0];
    dq_out  <= sel_d;
  end

  // A write flushes pending read data so the pins float at once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pv_r     <= 2'h0;
      dqm_d1_r <= 2'h3;
      dq_oe_n  <= 2'h3;
    end else begin
      dqm_d1_r <= pins.dqm;
      if (is_wr) begin
        pv_r    <= 2'h0;
        dq_oe_n <= 2'h3;
      end else begin
        pv_r    <= {pv_r[0], cur_v && !cur_wr};
        dq_oe_n <= ~({2{sel_v}} & ~dqm_d1_r);
      end
    end
  end

  // ==========================================================================
  // Power modes and refresh
  logic [sdram_pkg::REF_CNT_W-1:0] ref_cnt_r;
  logic [10:0]                     tick_cnt_r;
  logic                            self_tick, lost_r, lost_clr;

  assign self_tick = (mode_r == sdram_pkg::MODE_SELF) &&
      tick_cnt_r == 11'(sdram_pkg::REFRESH_INTERVAL_CYC - 1);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) mode_r <= sdram_pkg::MODE_RUN;
    else case (mode_r)
      sdram_pkg::MODE_RUN:
        if (!pins.cke && !pins.cs_n && cmd == sdram_pkg::CMD_REF)
          mode_r <= sdram_pkg::MODE_SELF;
        else if (!pins.cke && !pins.cs_n && cmd == sdram_pkg::CMD_BST &&
                 open_r == '0)
          mode_r <= sdram_pkg::MODE_DEEP;
      sdram_pkg::MODE_SELF, sdram_pkg::MODE_DEEP:
        if (pins.cke) mode_r <= sdram_pkg::MODE_RUN;
      default: mode_r <= sdram_pkg::MODE_RUN;
    endcase
  end

  // Internal interval timer; needs nothing from the pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tick_cnt_r <= 11'h000;
    else if (mode_r != sdram_pkg::MODE_SELF || self_tick)
      tick_cnt_r <= 11'h000;
    else tick_cnt_r <= tick_cnt_r + 11'h001;
  end

  // Address pins are ignored: the row comes from this counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) ref_cnt_r <= '0;
    else if (is_ref || self_tick) ref_cnt_r <= ref_cnt_r + 1'b1;
  end

  // Array contents flagged lost; entry wins over a clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) lost_r <= 1'b0;
    else if (mode_r == sdram_pkg::MODE_DEEP) lost_r <= 1'b1;
    else if (lost_clr) lost_r <= 1'b0;
  end

  // ==========================================================================
  // Wishbone slave: ack one cycle after request, dropped the next
  logic wb_req, wb_wr_now;
  assign wb_req    = wb_cyc_i && wb_stb_i;
  assign wb_wr_now = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign lost_clr  = wb_wr_now && wb_adr_i == sdram_pkg::STATUS_OFS &&
                     wb_dat_i[sdram_pkg::ST_LOST_POS];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      case (wb_adr_i)
        sdram_pkg::CFG_OFS:    wb_dat_o <= {28'h0, bl_code_r, cl_r};
        sdram_pkg::STATUS_OFS: wb_dat_o <= {24'h0, left_r != 4'h0, lost_r,
            mode_r == sdram_pkg::MODE_DEEP,
            mode_r == sdram_pkg::MODE_SELF, open_r};
        sdram_pkg::REFCNT_OFS: wb_dat_o <= {20'h0, ref_cnt_r};
        default:               wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Latency and burst length steer the read pipe and burst engine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cl_r      <= sdram_pkg::CL_RST;
      bl_code_r <= sdram_pkg::BL_RST;
    end else if (wb_wr_now && wb_adr_i == sdram_pkg::CFG_OFS) begin
      cl_r      <= wb_dat_i[sdram_pkg::CFG_CL_POS +: 2];
      bl_code_r <= wb_dat_i[sdram_pkg::CFG_BL_POS +: 2];
    end
  end

  // ==========================================================================
  // Assertions
  property p_ap_close;
    @(posedge mclk) disable iff (!reset_n)
    cur_v && cur_last_ap && !is_act |=> !open_r[$past(cur_bank)];
  endproperty
  a_ap_close: assert property (p_ap_close) else $error("bank left open");

  property p_ap_bit;
    @(posedge mclk) disable iff (!reset_n)
    is_col |=> bap_r == $past(pins.addr[sdram_pkg::AP_BIT]);
  endproperty
  a_ap_bit: assert property (p_ap_bit) else $error("ap bit lost");

  property p_ref_inc;
    @(posedge mclk) disable iff (!reset_n)
    is_ref |=> ref_cnt_r == $past(ref_cnt_r) + 1'b1;
  endproperty
  a_ref_inc: assert property (p_ref_inc) else $error("refresh miscount");

  property p_self_enter;
    @(posedge mclk) disable iff (!reset_n)
    mode_r == sdram_pkg::MODE_RUN && !pins.cke && !pins.cs_n &&
    cmd == sdram_pkg::CMD_REF |=> mode_r == sdram_pkg::MODE_SELF;
  endproperty
  a_self_enter: assert property (p_self_enter) else $error("no self");

  property p_self_tick;
    @(posedge mclk) disable iff (!reset_n)
    self_tick |=> ref_cnt_r == $past(ref_cnt_r) + 1'b1;
  endproperty
  a_self_tick: assert property (p_self_tick) else $error("no self ref");

  property p_deep;
    @(posedge mclk) disable iff (!reset_n)
    mode_r == sdram_pkg::MODE_DEEP && pins.cke |=>
      mode_r == sdram_pkg::MODE_RUN ##0 lost_r;
  endproperty
  a_deep: assert property (p_deep) else $error("deep exit wrong");

  property p_rd_lat2;
    @(posedge mclk) disable iff (!reset_n)
    is_rd && cl_r == 2'h2 && pins.dqm == 2'h0 ##1 !is_wr |=>
      dq_oe_n == 2'h0;
  endproperty
  a_rd_lat2: assert property (p_rd_lat2) else $error("read late");

  property p_wr_float;
    @(posedge mclk) disable iff (!reset_n)
    is_wr |=> dq_oe_n == 2'h3 ##1 dq_oe_n == 2'h3;
  endproperty
  a_wr_float: assert property (p_wr_float) else $error("drive on write");

  property p_rd_restart;
    @(posedge mclk) disable iff (!reset_n)
    is_rd |=> left_r == $past(bl) - 4'h1 && !bwr_r;
  endproperty
  a_rd_restart: assert property (p_rd_restart) else $error("no restart");

  c_read:  cover property (@(posedge mclk) is_rd ##3 dq_oe_n == 2'h0);
  c_write: cover property (@(posedge mclk) is_wr);
  c_self:  cover property (@(posedge mclk) self_tick);
  c_deep:  cover property (@(posedge mclk) mode_r == sdram_pkg::MODE_DEEP);

endmodule : sdram_device

// [verif/sdram_ctrl_model.sv]
// Behavioural memory controller that drives the device command pins.
// Assumes its tasks are called right after a rising mclk edge.
module sdram_ctrl_model #(
  parameter int ACTIVATE_TO_COLUMN_DELAY_CYC = 2,
  parameter int TRP_CYC  = 2,
  parameter int TRC_CYC  = 7,
  parameter int BANK_TO_BANK_ACTIVATE_DELAY_CYC = 2,
  parameter int REFRESH_CYCLE_TIME_CYC = 7,
  parameter int SELF_REFRESH_EXIT_TIME_CYC = 8
) (
  // Clock
  input  wire logic                        mclk,
  // Device side
  output sdram_pkg::sdram_pins_t           pins,
  output logic [sdram_pkg::DQ_W-1:0]       dq_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Command encodings and bank book-keeping
  localparam logic [2:0] OP_NOP = 3'h7;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_RD  = 3'h5;
  localparam logic [2:0] OP_WR  = 3'h4;
  localparam logic [2:0] OP_BST = 3'h6;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_REF = 3'h1;
  logic [3:0] open_r;
  logic       wr_drv;
  int         cyc;
  int         last_act [4];
  int         last_any;

  initial begin
    pins     = '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 cke: 1'b1, ba: 2'h0, addr: 12'h000, dqm: 2'h0};
    dq_in    = 16'h0000;
    wr_drv   = 1'b0;
    open_r   = 4'h0;
    cyc      = 0;
    last_any = -1000;
    foreach (last_act[k]) last_act[k] = -1000;
  end

  // Released data bus toggles so a stale value can never pass as data
  always @(posedge mclk) cyc <= cyc + 1;

  // Off the sampling edge, so it never races the write task's drive
  always @(negedge mclk) if (!wr_drv) dq_in <= ~dq_in;

  // ==========================================================================
  // Command tasks
  task automatic issue(input logic [2:0] op, input logic [1:0] ba,
                       input logic [11:0] a, input logic cke,
                       input logic [1:0] m);
    pins <= '{cs_n: 1'b0, ras_n: op[2], cas_n: op[1], we_n: op[0],
              cke: cke, ba: ba, addr: a, dqm: m};
    case (op)
      OP_ACT: begin
        open_r[ba]   = 1'b1;
        last_act[ba] = cyc;
        last_any     = cyc;
      end
      OP_PRE: if (a[sdram_pkg::AP_BIT]) open_r = 4'h0;
              else open_r[ba] = 1'b0;
      OP_RD, OP_WR: if (a[sdram_pkg::AP_BIT]) open_r[ba] = 1'b0;
      default: ;
    endcase
    @(posedge mclk);
  endtask : issue

  task automatic idle(input int n, input logic cke);
    repeat (n) issue(OP_NOP, 2'h0, 12'h000, cke, 2'h0);
  endtask : idle

  task automatic act(input logic [1:0] ba, input logic [11:0] row);
    if (open_r[ba]) begin
      issue(OP_PRE, ba, 12'h000, 1'b1, 2'h0);
      idle(TRP_CYC, 1'b1);
    end
    while (cyc - last_act[ba] < TRC_CYC) idle(1, 1'b1);
    while (cyc - last_any < BANK_TO_BANK_ACTIVATE_DELAY_CYC) idle(1, 1'b1);
    issue(OP_ACT, ba, row, 1'b1, 2'h0);
    idle(ACTIVATE_TO_COLUMN_DELAY_CYC, 1'b1);
  endtask : act

  task automatic rd(input logic [1:0] ba, input logic [7:0] col,
                    input logic ap);
    issue(OP_RD, ba, {1'b0, ap, 2'h0, col}, 1'b1, 2'h0);
  endtask : rd

  // Two-element write; mask low so the data lands
  task automatic wr(input logic [1:0] ba, input logic [7:0] col,
                    input logic [15:0] d0, input logic [15:0] d1);
    pins   <= '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b0, we_n: 1'b0, cke: 1'b1,
                ba: ba, addr: {4'h0, col}, dqm: 2'h0};
    dq_in  <= d0;
    wr_drv <= 1'b1;
    @(posedge mclk);
    pins   <= '{cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
                ba: 2'h0, addr: 12'h000, dqm: 2'h0};
    dq_in  <= d1;
    @(posedge mclk);
    wr_drv <= 1'b0;
  endtask : wr

  // Mask raised two edges ahead so read data never fights write data
  task automatic rd_to_wr(input logic [1:0] ba, input logic [7:0] col,
                          input logic [15:0] d0, input logic [15:0] d1);
    issue(OP_RD, ba, {4'h0, col}, 1'b1, 2'h3);
    issue(OP_NOP, 2'h0, 12'h000, 1'b1, 2'h3);
    wr(ba, col, d0, d1);
  endtask : rd_to_wr

  // Whole run is far shorter than one refresh window
  task automatic ref_cmd(input logic cke);
    if (|open_r) begin
      issue(OP_PRE, 2'h0, 12'h400, 1'b1, 2'h0);
      idle(TRP_CYC, 1'b1);
    end
    issue(OP_REF, 2'h0, 12'hFFF, cke, 2'h0);
    if (cke) idle(REFRESH_CYCLE_TIME_CYC, 1'b1);
  endtask : ref_cmd

  task automatic wake();
    idle(SELF_REFRESH_EXIT_TIME_CYC, 1'b1);
    ref_cmd(1'b1);
  endtask : wake

  task automatic deep();
    if (|open_r) begin
      issue(OP_PRE, 2'h0, 12'h400, 1'b1, 2'h0);
      idle(TRP_CYC, 1'b1);
    end
    issue(OP_BST, 2'h0, 12'h000, 1'b0, 2'h0);
  endtask : deep
endmodule : sdram_ctrl_model

// [verif/sdram_refresh_activate_read_ops_bench.sv]
// Self-checking bench for the device core: bus registers and pin commands.
// Assumes the controller model file is compiled beforehand.
module sdram_refresh_activate_read_ops_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                   mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]             wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o, rv, r1;
  sdram_pkg::sdram_pins_t pins;
  logic [15:0]            dq_in, dq_out;
  logic [1:0]             dq_oe_n;
  int                     n_fail, n_tests;

  sdram_device i_sdram_device (.mclk(mclk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  sdram_ctrl_model i_sdram_ctrl_model (.mclk(mclk), .pins(pins),
    .dq_in(dq_in));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Classic cycle; waits for ack with a bound, no fixed latency assumed
  task automatic wb_io(input logic we, input logic [7:0] adr,
                       input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= adr; wb_sel_i <= 4'hF; wb_dat_i <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50) chk("bus ack", 32'h1, 32'h0);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : wb_io

  task automatic reg_chk(input string what, input logic [7:0] adr,
                         input logic [31:0] exp);
    wb_io(1'b0, adr, 32'h0);
    chk(what, exp, rv);
  endtask : reg_chk

  // One burst element: driven byte lanes and data
  task automatic dq_chk(input logic [15:0] e);
    chk("output enable", 32'h0, {30'h0, dq_oe_n});
    chk("read data", {16'h0, e}, {16'h0, dq_out});
  endtask : dq_chk

  task automatic float_chk();
    chk("released bus", 32'h3, {30'h0, dq_oe_n});
  endtask : float_chk

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  // Watchdog: the sequence needs about 2000 cycles
  initial begin
    repeat (10000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    n_fail = 0; n_tests = 0; reset_n = 1'b0;
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    reg_chk("config reset", sdram_pkg::CFG_OFS, 32'(sdram_pkg::BL_RST) << 2
            | 32'(sdram_pkg::CL_RST));
    reg_chk("status reset", sdram_pkg::STATUS_OFS, 32'h0);
    reg_chk("unmapped", 8'hFC, 32'h0);
    wb_io(1'b1, sdram_pkg::CFG_OFS, 32'h6);  // Latency two, burst two
    reg_chk("config", sdram_pkg::CFG_OFS, 32'h6);
    // Write, then plain read keeps the row open
    i_sdram_ctrl_model.act(2'h1, 12'h005);
    i_sdram_ctrl_model.wr(2'h1, 8'h04, 16'hA5C3, 16'h5A3C);
    i_sdram_ctrl_model.rd(2'h1, 8'h04, 1'b0);
    i_sdram_ctrl_model.idle(2, 1'b1);
    dq_chk(16'hA5C3);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'h5A3C);
    i_sdram_ctrl_model.idle(1, 1'b1);
    float_chk();
    reg_chk("bank open", sdram_pkg::STATUS_OFS, 32'h2);
    // Back-to-back reads: second cuts the first after one element
    i_sdram_ctrl_model.rd(2'h1, 8'h05, 1'b0);
    i_sdram_ctrl_model.rd(2'h1, 8'h04, 1'b0);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'h5A3C);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'hA5C3);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'h5A3C);
    i_sdram_ctrl_model.idle(1, 1'b1);
    float_chk();
    // Read cut by a write under the mask
    i_sdram_ctrl_model.rd_to_wr(2'h1, 8'h04, 16'h1234, 16'hFEDC);
    float_chk();
    i_sdram_ctrl_model.idle(1, 1'b1);
    float_chk();
    // Burst terminate right after the read leaves a single element
    i_sdram_ctrl_model.rd(2'h1, 8'h04, 1'b0);
    i_sdram_ctrl_model.issue(i_sdram_ctrl_model.OP_BST, 2'h1, 12'h000,
                             1'b1, 2'h0);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'h1234);
    i_sdram_ctrl_model.idle(1, 1'b1);
    float_chk();
    i_sdram_ctrl_model.rd(2'h1, 8'h04, 1'b1);
    i_sdram_ctrl_model.idle(2, 1'b1);
    dq_chk(16'h1234);
    i_sdram_ctrl_model.idle(1, 1'b1);
    dq_chk(16'hFEDC);
    i_sdram_ctrl_model.idle(3, 1'b1);
    reg_chk("bank closed", sdram_pkg::STATUS_OFS, 32'h0);
    // Auto refresh: exactly one row per command
    wb_io(1'b0, sdram_pkg::REFCNT_OFS, 32'h0);
    r1 = rv;
    i_sdram_ctrl_model.ref_cmd(1'b1);
    i_sdram_ctrl_model.ref_cmd(1'b1);
    reg_chk("refresh count", sdram_pkg::REFCNT_OFS, (r1 + 2) & 32'hFFF);
    // Self refresh: pins ignored, one internal refresh per interval
    i_sdram_ctrl_model.ref_cmd(1'b0);
    i_sdram_ctrl_model.idle(3, 1'b0);
    reg_chk("self mode", sdram_pkg::STATUS_OFS, 32'h10);
    wb_io(1'b0, sdram_pkg::REFCNT_OFS, 32'h0);
    r1 = rv;
    i_sdram_ctrl_model.idle(1600, 1'b0);
    reg_chk("self count", sdram_pkg::REFCNT_OFS, (r1 + 1) & 32'hFFF);
    i_sdram_ctrl_model.wake();
    reg_chk("self exit", sdram_pkg::STATUS_OFS, 32'h0);
    reg_chk("exit count", sdram_pkg::REFCNT_OFS, (r1 + 2) & 32'hFFF);
    // Deep power-down, exit and the contents-lost flag
    i_sdram_ctrl_model.deep();
    i_sdram_ctrl_model.idle(3, 1'b0);
    reg_chk("deep mode", sdram_pkg::STATUS_OFS, 32'h60);
    i_sdram_ctrl_model.idle(2, 1'b1);
    reg_chk("deep exit", sdram_pkg::STATUS_OFS, 32'h40);
    wb_io(1'b1, sdram_pkg::STATUS_OFS, 32'h40);
    reg_chk("lost cleared", sdram_pkg::STATUS_OFS, 32'h0);
    stop_test();
  end
endmodule : sdram_refresh_activate_read_ops_bench
